//--- hdl/lbt_pkg.sv
package lbt_pkg;
    typedef struct packed {
        logic dma_en1;
        logic dma_en0;
        logic int_en;
        logic clk_sel;
        logic ref_sel;
        logic diff_mode;
    } lbt_ctrl_s;

    typedef struct packed {
        logic [1:0] req;
        logic       irq;
    } lbt_event_s;

    typedef struct packed {
        logic ref_sel;
        logic clk_sel;
    } lbt_clk_s;
endpackage

//--- hdl/lbt_regs.svh
// Operation
// RL1: Address and data share one 32-bit path
// RL2: Bridge masters the bus; FPGA answers as target
// RL3: Two DMA request/ack pairs, one local interrupt
// RL4: Buffer sustains single-clock back-to-back bursts; here a FIFO write takes at least three clocks and a read at least two
// RL5: Address bit 22 selects registers or FIFO
// RL6: Bridge forces bit 22 per address window
// RL7: FIFO space ignores address bits 21 to 2
// RL8: FIFO window spans 4 MB by default
// RL9: Fixed-address DMA permits a smaller FIFO window
// RL10: EEPROM holds 44, 11, 9 word regions
// RL11: Configuration image loads through bridge pins
// RL12: Acknowledges stay inactive until logic drives them
// RL13: Local bus runs on one synthesized clock
// RL14: Synthesizer reference from host clock or oscillator
// RL15: Synthesizers undefined until reprogrammed after reset
// RL16: Each differential transceiver carries eight bits
// RL17: Four blocks, each input or output
// RL18: All lines of one block share direction
// RL19: All blocks use one signalling standard
// RL20: Register window is 64 KB memory space
// RL21: DMA request only when FIFO can move
// RL22: Blocks default to input after configuration
`ifndef LBT_REGS_SVH
`define LBT_REGS_SVH

`define LBT_AW            23
`define LBT_DW            32
`define LBT_SPACE_BIT     22
`define LBT_IDX_HI        7
`define LBT_IDX_LO        2
`define LBT_IDX_W         6

`define LBT_IDX_CTRL      6'h00
`define LBT_IDX_DIR       6'h01
`define LBT_IDX_TX_LO     6'h02
`define LBT_IDX_TX_HI     6'h03
`define LBT_IDX_RX_LO     6'h04
`define LBT_IDX_RX_HI     6'h05
`define LBT_IDX_STATUS    6'h06

`define LBT_CTRL_DIFF     0
`define LBT_CTRL_REFSEL   1
`define LBT_CTRL_CLKSEL   2
`define LBT_CTRL_INTEN    3
`define LBT_CTRL_DMAEN0   4
`define LBT_CTRL_DMAEN1   5
`define LBT_CTRL_W        6
`define LBT_CTRL_RST      6'h00
`define LBT_DIR_RST       4'h0

`define LBT_BLOCKS        4
`define LBT_LINES         16
`define LBT_DIFF_LINES    8
`define LBT_IO_W          64

`define LBT_FIFO_DEPTH    16
`define LBT_FIFO_AW       4
`define LBT_RESP_OKAY     2'h0
`define LBT_RESP_SLVERR   2'h2

`endif

//--- hdl/lbt_target.sv
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "lbt_regs.svh"
module lbt_target (
    // Clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite slave
    input  wire logic [22:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output      logic                   s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output      logic                   s_axi_wready,
    output      logic [1:0]             s_axi_bresp,
    output      logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [22:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output      logic                   s_axi_arready,
    output      logic [31:0]            s_axi_rdata,
    output      logic [1:0]             s_axi_rresp,
    output      logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // DMA handshake and local interrupt
    output      lbt_pkg::lbt_event_s    dma_irq_out,
    input  wire logic [1:0]             dma_ack,
    // Clock synthesizer selection
    output      lbt_pkg::lbt_clk_s      clk_select,
    // Link clock
    input  wire logic                   link_clk,
    // Front connector lines
    input  wire logic [63:0]            io_in,
    output      logic [63:0]            io_out,
    output      logic [63:0]            io_oe_n,
    output      logic [3:0]             xcvr_drive
);
    import lbt_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register state
    lbt_ctrl_s          ctrl_q;
    logic [3:0]         dir_q;
    logic [63:0]        tx_q;
    logic [63:0]        rx_q;
    logic [63:0]        out_q;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    logic               aw_got_q;
    logic               w_got_q;
    logic [22:0]        aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;

    // Acknowledges are low in reset and whenever busy RL12
    assign s_axi_awready = aresetn && !aw_got_q && !bvalid_q;
    assign s_axi_wready  = aresetn && !w_got_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    wire aw_hs   = s_axi_awvalid && s_axi_awready;
    wire w_hs    = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_got_q && w_got_q; // RL2
    // Bit 22 chooses register or FIFO space RL5
    wire wr_fifo = aw_addr_q[`LBT_SPACE_BIT];
    wire [`LBT_IDX_W-1:0] wr_idx = aw_addr_q[`LBT_IDX_HI:`LBT_IDX_LO];
    wire wr_reg_hit = !wr_fifo && (wr_idx <= `LBT_IDX_TX_HI);

    ////////////////////////////////////////////////////////////////////////
    // Buffer FIFO, one word per access RL4
    logic [31:0]                mem_q [`LBT_FIFO_DEPTH];
    logic [`LBT_FIFO_AW:0]      wptr_q;
    logic [`LBT_FIFO_AW:0]      rptr_q;
    wire  [`LBT_FIFO_AW:0]      fcount = wptr_q - rptr_q;
    wire                        fempty = (wptr_q == rptr_q);
    wire                        ffull  = (fcount == (`LBT_FIFO_AW+1)'(`LBT_FIFO_DEPTH));

    ////////////////////////////////////////////////////////////////////////
    // Read channel
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;

    assign s_axi_arready = aresetn && !rvalid_q; // RL12
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire ar_hs   = s_axi_arvalid && s_axi_arready;
    // Bits 21..2 take no part in FIFO reads RL7
    wire rd_fifo = s_axi_araddr[`LBT_SPACE_BIT];
    wire [`LBT_IDX_W-1:0] rd_idx = s_axi_araddr[`LBT_IDX_HI:`LBT_IDX_LO];
    wire fifo_pop  = ar_hs && rd_fifo && !fempty;
    wire fifo_push = wr_go && wr_fifo && !ffull;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, three stages, agreement of two and three
    logic [63:0]        io_s1_q;
    logic [63:0]        io_s2_q;
    logic [63:0]        io_s3_q;
    logic [63:0]        io_lvl_q;
    logic [2:0]         lk_s_q;
    logic               lk_lvl_q;
    logic [1:0]         ak_s1_q;
    logic [1:0]         ak_s2_q;
    logic [1:0]         ak_s3_q;
    logic [1:0]         ak_lvl_q;

    wire [63:0] io_agree = ~(io_s2_q ^ io_s3_q);
    wire [63:0] io_lvl_d = (io_s3_q & io_agree) | (io_lvl_q & ~io_agree);
    wire [1:0]  ak_agree = ~(ak_s2_q ^ ak_s3_q);
    wire [1:0]  ak_lvl_d = (ak_s3_q & ak_agree) | (ak_lvl_q & ~ak_agree);
    wire        lk_agree = (lk_s_q[1] == lk_s_q[2]);
    wire        lk_lvl_d = lk_agree ? lk_s_q[2] : lk_lvl_q;
    // I/O is timed by the link clock, found by the bus clock RL13
    wire        lk_rise  = lk_lvl_d && !lk_lvl_q;

    ////////////////////////////////////////////////////////////////////////
    // Line masks for mode and direction
    logic [63:0]        drv_mask;
    logic [63:0]        lane_mask;
    always_comb begin
        for (int b = 0; b < `LBT_BLOCKS; b++) begin
            for (int i = 0; i < `LBT_LINES; i++) begin
                // One mode for all blocks; eight lines per transceiver RL19 RL16
                lane_mask[b*`LBT_LINES+i] = !ctrl_q.diff_mode || (i < `LBT_DIFF_LINES);
                // One direction bit per block RL17 RL18
                drv_mask[b*`LBT_LINES+i]  = dir_q[b] && lane_mask[b*`LBT_LINES+i];
            end
        end
    end

    assign io_out     = out_q;
    assign io_oe_n    = ~drv_mask;
    assign xcvr_drive = dir_q; // RL18

    // Requests follow FIFO room and content RL21 RL3
    assign dma_irq_out.req[0] = ctrl_q.dma_en0 && !ffull;
    assign dma_irq_out.req[1] = ctrl_q.dma_en1 && !fempty;
    assign dma_irq_out.irq    = ctrl_q.int_en && !fempty; // RL3

    // Synthesizer reference and FPGA timing source RL14 RL13
    assign clk_select.ref_sel = ctrl_q.ref_sel;
    assign clk_select.clk_sel = ctrl_q.clk_sel;

    ////////////////////////////////////////////////////////////////////////
    // Register read mux
    wire [31:0] status_w = {20'h00000, lk_lvl_q, ak_lvl_q, ffull, fempty,
                            2'h0, fcount};
    logic [31:0]        reg_rd;
    logic               reg_hit;
    always_comb begin
        reg_hit = 1'b1;
        case (rd_idx)
            `LBT_IDX_CTRL:   reg_rd = {26'h0000000, ctrl_q};
            `LBT_IDX_DIR:    reg_rd = {28'h0000000, dir_q};
            `LBT_IDX_TX_LO:  reg_rd = tx_q[31:0];
            `LBT_IDX_TX_HI:  reg_rd = tx_q[63:32];
            `LBT_IDX_RX_LO:  reg_rd = rx_q[31:0];
            `LBT_IDX_RX_HI:  reg_rd = rx_q[63:32];
            `LBT_IDX_STATUS: reg_rd = status_w;
            default: begin
                reg_rd  = 32'h00000000;
                reg_hit = 1'b0;
            end
        endcase
    end

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (st[k]) begin
                r[k*8 +: 8] = nw[k*8 +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] ctrl_new = merge({26'h0000000, ctrl_q}, w_data_q, w_strb_q);
    wire [31:0] dir_new  = merge({28'h0000000, dir_q}, w_data_q, w_strb_q);
    wire [31:0] txl_new  = merge(tx_q[31:0], w_data_q, w_strb_q);
    wire [31:0] txh_new  = merge(tx_q[63:32], w_data_q, w_strb_q);
    wire        reg_wr   = wr_go && wr_reg_hit;

    ////////////////////////////////////////////////////////////////////////
    // Write handshake and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            aw_addr_q <= 23'h000000;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `LBT_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_q  <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wr_fifo ? !ffull : wr_reg_hit) ? `LBT_RESP_OKAY
                                                            : `LBT_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Control registers; direction resets to input RL22
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `LBT_CTRL_RST;
            dir_q  <= `LBT_DIR_RST; // RL22
            tx_q   <= 64'h0000000000000000;
        end else if (reg_wr) begin
            case (wr_idx)
                `LBT_IDX_CTRL:  ctrl_q      <= ctrl_new[`LBT_CTRL_W-1:0];
                `LBT_IDX_DIR:   dir_q       <= dir_new[3:0];
                `LBT_IDX_TX_LO: tx_q[31:0]  <= txl_new;
                `LBT_IDX_TX_HI: tx_q[63:32] <= txh_new;
                default:        ctrl_q      <= ctrl_q;
            endcase
        end
    end

    // FIFO storage and pointers, one push and one pop per clock RL4
    always_ff @(posedge aclk) begin
        if (fifo_push) begin
            mem_q[wptr_q[`LBT_FIFO_AW-1:0]] <= w_data_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            if (fifo_push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (fifo_pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
        end
    end

    // Read response, one cycle after the address is taken RL1
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `LBT_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            if (rd_fifo) begin // RL5 RL7
                rdata_q <= fempty ? 32'h00000000 : mem_q[rptr_q[`LBT_FIFO_AW-1:0]];
                rresp_q <= `LBT_RESP_OKAY;
            end else begin
                rdata_q <= reg_rd;
                rresp_q <= reg_hit ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_s1_q  <= 64'h0000000000000000;
            io_s2_q  <= 64'h0000000000000000;
            io_s3_q  <= 64'h0000000000000000;
            io_lvl_q <= 64'h0000000000000000;
            lk_s_q   <= 3'h0;
            lk_lvl_q <= 1'b0;
            ak_s1_q  <= 2'h0;
            ak_s2_q  <= 2'h0;
            ak_s3_q  <= 2'h0;
            ak_lvl_q <= 2'h0;
        end else begin
            io_s1_q  <= io_in;
            io_s2_q  <= io_s1_q;
            io_s3_q  <= io_s2_q;
            io_lvl_q <= io_lvl_d;
            lk_s_q   <= {lk_s_q[1:0], link_clk};
            lk_lvl_q <= lk_lvl_d;
            ak_s1_q  <= dma_ack;
            ak_s2_q  <= ak_s1_q;
            ak_s3_q  <= ak_s2_q;
            ak_lvl_q <= ak_lvl_d;
        end
    end

    // Link-edge transfer of line data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_q <= 64'h0000000000000000;
            rx_q  <= 64'h0000000000000000;
        end else if (lk_rise) begin
            out_q <= tx_q & drv_mask; // RL17 RL16
            rx_q  <= io_lvl_d & ~drv_mask & lane_mask; // RL19
        end
    end
endmodule

//--- verif/lbt_link_peer.sv
`timescale 1ns/1ns
module lbt_link_peer (
    // Frame control
    input  wire logic        go,
    input  wire logic [63:0] pat,
    output      logic        busy,
    // Far-end lines
    output      logic        link_clk,
    output      logic [63:0] io_in
);
    initial begin
        busy = 1'b0;
        link_clk = 1'b0;
        io_in = 64'h0;
        forever begin
            @(posedge go);
            busy = 1'b1;
            io_in = pat;
            #3;
            repeat (4) begin
                #80 link_clk = 1'b1;
                #80 link_clk = 1'b0;
            end
            // Lines change after the frame so stale data cannot pass for held data
            #40 io_in = ~io_in;
            busy = 1'b0;
        end
    end
endmodule

//--- verif/lbt_target_asserts.sv
`timescale 1ns/1ns
module lbt_target_asserts (
    // Clock and reset
    input wire logic                aclk,
    input wire logic                aresetn,
    // Bus handshakes
    input wire logic                s_axi_awvalid,
    input wire logic                s_axi_awready,
    input wire logic                s_axi_wvalid,
    input wire logic                s_axi_wready,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic                s_axi_rready,
    // Events and lines
    input wire lbt_pkg::lbt_event_s dma_irq_out,
    input wire logic                link_clk,
    input wire logic [63:0]         io_out,
    input wire logic [63:0]         io_oe_n,
    input wire logic [3:0]          xcvr_drive
);
    import lbt_pkg::*;
    wire logic [63:0] blk_out;
    assign blk_out = {{16{xcvr_drive[3]}}, {16{xcvr_drive[2]}},
                      {16{xcvr_drive[1]}}, {16{xcvr_drive[0]}}};
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////
    rst_quiet_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && (&io_oe_n) && xcvr_drive == 4'h0 && dma_irq_out == 3'h0)
        else $error("outputs active after reset");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read not answered");
    rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer not retired");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not retired");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    blk_dir_a: assert property (&(io_oe_n | blk_out))
        else $error("input block line driven");
    io_link_a: assert property ($changed(io_out) |-> link_clk)
        else $error("lines moved without link edge");
endmodule
bind lbt_target lbt_target_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dma_irq_out(dma_irq_out), .link_clk(link_clk), .io_out(io_out),
    .io_oe_n(io_oe_n), .xcvr_drive(xcvr_drive));

//--- verif/tb.sv
`timescale 1ns/1ns
`include "lbt_regs.svh"
module tb;
    import lbt_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic        awr, wrdy, bv, arr, rv, local_bus_clock, busy;
    logic [22:0] awa = 23'h0, ara = 23'h0;
    logic [31:0] wd = 32'h0, rdat, d;
    logic [1:0]  ack = 2'h0, br, rr, r;
    logic [63:0] p = 64'h0, ioi, ioo, oen, m;
    logic [3:0]  xd;
    lbt_event_s  ev;
    lbt_clk_s    cs;
    int          n_mismatch = 0, cmp_count = 0;
    localparam logic [63:0] TX = 64'h0123456789ABCDEF;
    localparam logic [63:0] PT = 64'hA5C35A3CF00F0FF0;
    always #2 aclk = ~aclk;
    lbt_target u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rrdy), .dma_irq_out(ev), .dma_ack(ack), .clk_select(cs),
        .link_clk(local_bus_clock), .io_in(ioi), .io_out(ioo), .io_oe_n(oen), .xcvr_drive(xd));
    lbt_link_peer u_peer (.go(go), .pat(p), .busy(busy), .link_clk(local_bus_clock), .io_in(ioi));
    ////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic to_chk(input logic hit);
        if (hit) begin
            n_mismatch++;
            $display("MISMATCH wait exp done got timeout");
            wrap_up();
        end
    endtask
    function automatic logic [22:0] ra(input logic [5:0] i);
        return {15'h0000, i, 2'b00};
    endfunction
    task automatic wr(input logic [22:0] a, input logic [31:0] dd, output logic [1:0] rs);
        int n;
        logic pa, pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        awa <= a;
        wd <= dd;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        while ((pa || pw) && n < 64) begin
            @(posedge aclk);
            n++;
            if (awr) pa = 1'b0;
            if (wrdy) pw = 1'b0;
            awv <= pa;
            wv <= pw;
        end
        while (!bv && n < 64) begin
            @(posedge aclk);
            n++;
        end
        brdy <= 1'b0;
        rs = br;
        to_chk(n >= 64);
        @(posedge aclk);
    endtask
    task automatic rd(input logic [22:0] a, output logic [31:0] dd, output logic [1:0] rs);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (!arr && n < 64);
        arv <= 1'b0;
        while (!rv && n < 64) begin
            @(posedge aclk);
            n++;
        end
        rrdy <= 1'b0;
        dd = rdat;
        rs = rr;
        to_chk(n >= 64);
        @(posedge aclk);
    endtask
    task automatic frame(input logic [63:0] pp);
        int n;
        n = 0;
        p <= pp;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (busy && n < 400);
        to_chk(n >= 400);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        ack <= 2'b10;
        @(posedge aclk);
        chk("oe_n_rst", 64'hFFFFFFFFFFFFFFFF, oen);
        rd(ra(`LBT_IDX_DIR), d, r);
        chk("dir_rst", {`LBT_RESP_OKAY, 32'h0}, {r, d});
        rd(ra(6'h3F), d, r);
        chk("bad_rd", {`LBT_RESP_SLVERR, 32'h0}, {r, d});
        wr(ra(`LBT_IDX_STATUS), 32'h0, r);
        chk("ro_wr", `LBT_RESP_SLVERR, r);
        for (int i = 1; i < 4; i++) begin
            wr(ra(`LBT_IDX_CTRL), 32'(i << 1), r);
            chk("clk_sel", {i[0], i[1]}, cs);
        end
        wr(ra(`LBT_IDX_TX_LO), TX[31:0], r);
        wr(ra(`LBT_IDX_TX_HI), TX[63:32], r);
        wr(ra(`LBT_IDX_DIR), 32'h5, r);
        m = 64'h0000FFFF0000FFFF;
        chk("xcvr", 4'h5, xd);
        chk("oe_se", ~m, oen);
        frame(PT);
        chk("out_se", TX & m, ioo);
        rd(ra(`LBT_IDX_RX_LO), d, r);
        chk("rx_lo", PT[31:0] & ~m[31:0], d);
        rd(ra(`LBT_IDX_RX_HI), d, r);
        chk("rx_hi", PT[63:32] & ~m[63:32], d);
        wr(ra(`LBT_IDX_CTRL), 32'h1, r);
        wr(ra(`LBT_IDX_DIR), 32'h3, r);
        m = 64'h0000000000FF00FF;
        frame(PT);
        chk("out_diff", TX & m, ioo);
        chk("oe_diff", ~m, oen);
        rd(ra(`LBT_IDX_RX_HI), d, r);
        chk("rx_diff", PT[63:32] & 32'h00FF00FF, d);
        wr(ra(`LBT_IDX_CTRL), 32'h38, r);
        chk("ev_idle", 3'b010, ev);
        for (int i = 0; i < 17; i++) begin
            wr({1'b1, 20'(i * 3001), 2'b00}, 32'hC0DE0000 + 32'(i), r);
            chk("fifo_wr", (i < 16) ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR, r);
        end
        chk("ev_full", 3'b101, ev);
        rd(ra(`LBT_IDX_STATUS), d, r);
        chk("status", {5'h0A, 5'h10}, {d[11:7], d[4:0]});
        for (int i = 0; i < 16; i++) begin
            rd({1'b1, 20'(i * 7777), 2'b00}, d, r);
            chk("fifo_rd", 32'hC0DE0000 + 32'(i), d);
        end
        rd(23'h7FFFFC, d, r);
        chk("empty_rd", {`LBT_RESP_OKAY, 32'h0}, {r, d});
        chk("ev_empty", 3'b010, ev);
        wrap_up();
    end
endmodule
